//--- hw/extra_ext_irq_and_aux_port.v
// Extra external interrupts, eight-source two-level arbiter and the
// 4-bit auxiliary port. Assumes the core issues byte and bit accesses
// to special function registers and pulses acknowledge and return.
//
// Operation
// RULE1 - Two extra external interrupts behave like the two standard ones.
// RULE2 - Control register sits at 0C0H and its bits are bit addressable.
// RULE3 - Control bits 7..0: prioB enB flagB edgeB prioA enA flagA edgeA.
// RULE4 - Priority bit set means high priority, clear means low.
// RULE5 - An extra interrupt requests service only while its enable is set.
// RULE6 - Edge select set means falling edge, clear means low level.
// RULE7 - Edge mode: flag set on edge, cleared when vectored to.
// RULE8 - Six standard vectors 03H..2BH, enabled by enable register bits 0..5.
// RULE9 - Interrupt A vectors to 33H, polled seventh, enable bit 2, type bit 0.
// RULE10 - Interrupt B vectors to 3BH, polled last among equal priority.
// RULE11 - Auxiliary port at 0D8H, low 4 bits usable, quasi-bidirectional.
// RULE12 - Port bits 3 and 2 double as the extra interrupt pins.
// RULE13 - Port write drives pins, read gives pins, modify-writes use latch.
// RULE14 - Reset sets port latches to all ones and control register to zero.
// RULE15 - High priority first, equal level by polling, only high nests low.
// RULE16 - Level mode flag follows inverted pin and is not cleared on service.
`include "extra_irq_consts.vh"
`default_nettype none

module extra_ext_irq_and_aux_port (
  // Clock and reset.
  input  wire       clk,
  input  wire       rstn,
  // Special function register access from the core.
  input  wire [7:0] sfrAddr,
  input  wire       sfrWr,
  input  wire [7:0] sfrWrData,
  input  wire       sfrRmw,
  output reg  [7:0] sfrRdData,
  input  wire       bitWr,
  input  wire [7:0] bitAddr,
  input  wire       bitVal,
  // Standard interrupt sources and core enable and priority registers.
  input  wire [5:0] stdReq,
  input  wire [7:0] irqEnableReg,
  input  wire [5:0] stdPrioHigh,
  // Interrupt handshake with the core.
  output reg        intReq,
  output reg  [7:0] intVector,
  input  wire       intAck,
  input  wire       intReturn,
  // Auxiliary port pins.
  input  wire [3:0] auxPinIn,
  output wire [3:0] auxPinOut,
  output wire [3:0] auxPinOe
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // True when a bit address selects a bit of the register at base.
  function hitsReg;
    input [7:0] addr;
    input [7:0] base;
    begin
      hitsReg = (addr[7:3] == base[7:3]);
    end
  endfunction

  // Vector address of a source number.
  function [7:0] vecOf;
    input [2:0] src;
    begin
      vecOf = `VEC_BASE + {2'b00, src, 3'b000};
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  reg  [7:0] extra_irq_control_r;
  reg  [7:0] extra_irq_control_nxt;
  reg  [3:0] auxiliary_port_latch_r;
  reg  [3:0] auxiliary_port_latch_nxt;
  reg  [3:0] pinMeta_r;
  reg  [3:0] pinSync_r;
  reg  [1:0] pinPrev_r;
  reg  [1:0] inService_r;
  reg  [1:0] inService_nxt;
  reg  [2:0] grantSrc_r;
  reg        grantHigh_r;
  reg        grantValid_r;

  wire       extIrqPinA = pinSync_r[`PIN_A_BIT];
  wire       extIrqPinB = pinSync_r[`PIN_B_BIT];
  wire       fallA      = pinPrev_r[0] & ~extIrqPinA;
  wire       fallB      = pinPrev_r[1] & ~extIrqPinB;
  wire       ackA       = intAck & grantValid_r & (grantSrc_r == 3'd6);
  wire       ackB       = intAck & grantValid_r & (grantSrc_r == 3'd7);

  // Quasi-bidirectional: a zero latch pulls the pin low, a one lets
  // the pull-up hold it high so the pin can serve as an input. [RULE11]
  assign auxPinOut = 4'h0;
  assign auxPinOe  = ~auxiliary_port_latch_r; // [RULE13]

  // ----------------------------------------------------------------
  // Register write and flag logic
  // ----------------------------------------------------------------

  always @*
  begin
    extra_irq_control_nxt    = extra_irq_control_r;
    auxiliary_port_latch_nxt = auxiliary_port_latch_r;
    if (sfrWr && sfrAddr == `CTRL_ADDR) // [RULE2]
      extra_irq_control_nxt = sfrWrData; // [RULE3]
    if (sfrWr && sfrAddr == `PORT_ADDR)
      auxiliary_port_latch_nxt = sfrWrData[3:0]; // [RULE13]
    if (bitWr && hitsReg(bitAddr, `CTRL_ADDR))
      extra_irq_control_nxt[bitAddr[2:0]] = bitVal; // [RULE2]
    if (bitWr && hitsReg(bitAddr, `PORT_ADDR) && !bitAddr[2])
      auxiliary_port_latch_nxt[bitAddr[1:0]] = bitVal; // [RULE11]
    // Service clears an edge flag; a new edge in the same cycle wins.
    if (extra_irq_control_r[`A_EDGE_BIT])
    begin
      if (ackA)
        extra_irq_control_nxt[`A_FLAG_BIT] = 1'b0; // [RULE7]
      if (fallA)
        extra_irq_control_nxt[`A_FLAG_BIT] = 1'b1; // [RULE6] [RULE7]
    end
    else
      extra_irq_control_nxt[`A_FLAG_BIT] = ~extIrqPinA; // [RULE16]
    if (extra_irq_control_r[`B_EDGE_BIT])
    begin
      if (ackB)
        extra_irq_control_nxt[`B_FLAG_BIT] = 1'b0; // [RULE7]
      if (fallB)
        extra_irq_control_nxt[`B_FLAG_BIT] = 1'b1; // [RULE6] [RULE7]
    end
    else
      extra_irq_control_nxt[`B_FLAG_BIT] = ~extIrqPinB; // [RULE16]
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------

  wire [7:0] srcReq;
  wire [7:0] srcHigh;
  assign srcReq[5:0] = stdReq & irqEnableReg[5:0]; // [RULE8]
  assign srcReq[6]   = extra_irq_control_r[`A_FLAG_BIT] &
                       extra_irq_control_r[`A_EN_BIT]; // [RULE5] [RULE9]
  assign srcReq[7]   = extra_irq_control_r[`B_FLAG_BIT] &
                       extra_irq_control_r[`B_EN_BIT]; // [RULE5] [RULE10]
  assign srcHigh[5:0] = stdPrioHigh;
  assign srcHigh[6]   = extra_irq_control_r[`A_PRIO_BIT]; // [RULE4]
  assign srcHigh[7]   = extra_irq_control_r[`B_PRIO_BIT]; // [RULE4]

  reg  [2:0] winSrc;
  reg        winHigh;
  reg        winAny;
  integer    i;

  // Scanning from the last source down leaves the first in polling
  // order as winner within each level; high level overrides low.
  always @*
  begin
    winSrc  = 3'd0;
    winHigh = 1'b0;
    winAny  = 1'b0;
    for (i = `NUM_SOURCES - 1; i >= 0; i = i - 1)
    begin
      if (srcReq[i] && !srcHigh[i] && !winHigh)
      begin
        winSrc = i[2:0]; // [RULE10]
        winAny = 1'b1;
      end
    end
    for (i = `NUM_SOURCES - 1; i >= 0; i = i - 1)
    begin
      if (srcReq[i] && srcHigh[i])
      begin
        winSrc  = i[2:0]; // [RULE15]
        winHigh = 1'b1;
        winAny  = 1'b1;
      end
    end
  end

  // A request may preempt only when nothing of its level or above runs.
  wire mayGrant = winAny & irqEnableReg[`GLOBAL_EN_BIT] & ~inService_r[1] &
                  (winHigh | ~inService_r[0]); // [RULE15]

  always @*
  begin
    inService_nxt = inService_r;
    if (intReturn)
    begin
      if (inService_r[1])
        inService_nxt[1] = 1'b0;
      else
        inService_nxt[0] = 1'b0;
    end
    if (intAck && grantValid_r)
    begin
      if (grantHigh_r)
        inService_nxt[1] = 1'b1; // [RULE15]
      else
        inService_nxt[0] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      extra_irq_control_r    <= `CTRL_RESET; // [RULE14]
      auxiliary_port_latch_r <= `PORT_RESET; // [RULE14]
      pinMeta_r              <= 4'hF;
      pinSync_r              <= 4'hF;
      pinPrev_r              <= 2'h3;
      inService_r            <= 2'h0;
      grantSrc_r             <= 3'h0;
      grantHigh_r            <= 1'b0;
      grantValid_r           <= 1'b0;
      intReq                 <= 1'b0;
      intVector              <= 8'h00;
    end
    else
    begin
      extra_irq_control_r    <= extra_irq_control_nxt;
      auxiliary_port_latch_r <= auxiliary_port_latch_nxt;
      pinMeta_r              <= auxPinIn;
      pinSync_r              <= pinMeta_r;
      pinPrev_r              <= {extIrqPinB, extIrqPinA}; // [RULE12]
      inService_r            <= inService_nxt;
      // The grant is held off in the acknowledge cycle so that a stale
      // winner is never presented after the core took a vector.
      grantValid_r           <= mayGrant & ~intAck;
      intReq                 <= mayGrant & ~intAck;
      grantSrc_r             <= winSrc;
      grantHigh_r            <= winHigh;
      intVector              <= vecOf(winSrc); // [RULE8] [RULE9] [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Plain reads return pin levels; read-modify-write reads the latch.
  always @*
  begin
    case (sfrAddr)
      `CTRL_ADDR: sfrRdData = extra_irq_control_r;
      `PORT_ADDR: sfrRdData = {4'h0, sfrRmw ? auxiliary_port_latch_r
                                            : pinSync_r}; // [RULE13]
      default:    sfrRdData = 8'h00;
    endcase
  end

  // Interrupts A and B mirror the standard external pair in behaviour. [RULE1]

endmodule

`default_nettype wire

//--- hw/extra_irq_consts.vh
// Constants for the extra external interrupt and auxiliary port block.
// Assumes a core that reaches special function registers by byte address.
`ifndef EXTRA_IRQ_CONSTS_VH
`define EXTRA_IRQ_CONSTS_VH

// Register addresses, also the bases of their bit addresses.
`define CTRL_ADDR      8'hC0
`define PORT_ADDR      8'hD8

// Field positions of the control register.
`define A_EDGE_BIT     0
`define A_FLAG_BIT     1
`define A_EN_BIT       2
`define A_PRIO_BIT     3
`define B_EDGE_BIT     4
`define B_FLAG_BIT     5
`define B_EN_BIT       6
`define B_PRIO_BIT     7

// Reset values.
`define CTRL_RESET     8'h00
`define PORT_RESET     4'hF

// Auxiliary port bits that carry the interrupt pins.
`define PIN_A_BIT      2
`define PIN_B_BIT      3

// Global enable bit of the core's enable register.
`define GLOBAL_EN_BIT  7

// Vector address base and step: vector = base + 8 * source.
`define VEC_BASE       8'h03
`define NUM_SOURCES    8

`endif

//--- verif/extra_irq_monitor.sv
// Checker for the extra interrupt and auxiliary port block.
// Assumes one clock domain with the asynchronous active-low reset.
`default_nettype none
module extra_irq_monitor (
  // Clock, reset and register access.
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWr,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRmw,
  input wire logic [7:0] sfrRdData,
  input wire logic       bitWr,
  input wire logic [7:0] bitAddr,
  input wire logic       bitVal,
  // Interrupt handshake and port.
  input wire logic [7:0] irqEnableReg,
  input wire logic       intReq,
  input wire logic [7:0] intVector,
  input wire logic       intAck,
  input wire logic [3:0] auxPinOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_port_oe_write: assert property (
    sfrWr && sfrAddr == 8'hD8 && !bitWr |=>
    auxPinOe == ~$past(sfrWrData[3:0])) else $error("port drive wrong");
  a_rmw_reads_latch: assert property (
    sfrAddr == 8'hD8 && sfrRmw |-> sfrRdData == {4'h0, ~auxPinOe})
    else $error("latch read wrong");
  a_unmapped_reads_zero: assert property (
    sfrAddr != 8'hC0 && sfrAddr != 8'hD8 |-> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  a_port_high_zero: assert property (
    sfrAddr == 8'hD8 |-> sfrRdData[7:4] == 4'h0)
    else $error("port upper bits set");
  a_global_off: assert property (
    !irqEnableReg[7] ##1 !irqEnableReg[7] |-> !intReq)
    else $error("request with global enable off");
  a_vector_legal: assert property (
    intReq |-> intVector[2:0] == 3'h3 && intVector <= 8'h3B)
    else $error("illegal vector");
  a_ack_drops_req: assert property (
    intAck && intReq |=> !intReq) else $error("request held after ack");
  a_bit_enable_a: assert property (
    bitWr && bitAddr == 8'hC2 ##1 sfrAddr == 8'hC0 |->
    sfrRdData[2] == $past(bitVal)) else $error("bit write lost");
  c_vec_a: cover property (intReq && intVector == 8'h33);
  c_vec_b: cover property (intReq && intVector == 8'h3B);
  c_ack: cover property (intAck && intReq);
endmodule
bind extra_ext_irq_and_aux_port extra_irq_monitor i_mon (.clk, .rstn,
  .sfrAddr, .sfrWr, .sfrWrData, .sfrRmw, .sfrRdData, .bitWr, .bitAddr,
  .bitVal, .irqEnableReg, .intReq, .intVector, .intAck, .auxPinOe);
`default_nettype wire

//--- verif/ext_pin_model.sv
// Devices and pull-ups on the auxiliary port pins.
// Assumes the block pulls a pin low while its enable is high.
`default_nettype none
module ext_pin_model (
  // Pin side.
  input  wire logic [3:0] auxPinOe,
  input  wire logic [3:0] extLevel,
  output logic      [3:0] auxPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-and, so a released pin returns to the pull-up level.
  assign auxPinIn = extLevel & ~auxPinOe;
endmodule
`default_nettype wire

//--- verif/extra_ext_irq_and_aux_port_tb.sv
// Testbench for the extra interrupt and auxiliary port block.
// Assumes the pin model supplies the port pull-ups.
`default_nettype none
module extra_ext_irq_and_aux_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rstn = 0, sfrWr = 0, sfrRmw = 0, bitWr = 0;
  logic       bitVal = 0, intAck = 0, intReturn = 0;
  logic [7:0] sfrAddr = 0, sfrWrData = 0, bitAddr = 0, irqEnableReg = 0;
  logic [5:0] stdReq = 0, stdPrioHigh = 0;
  logic [3:0] extLevel = 4'hF;
  wire  [7:0] sfrRdData, intVector;
  wire  [3:0] auxPinIn, auxPinOut, auxPinOe;
  wire        intReq;
  int         error_cnt = 0, comparisons = 0;
  always #50 clk = ~clk;
  extra_ext_irq_and_aux_port i_dut (.clk, .rstn, .sfrAddr, .sfrWr,
    .sfrWrData, .sfrRmw, .sfrRdData, .bitWr, .bitAddr, .bitVal, .stdReq,
    .irqEnableReg, .stdPrioHigh, .intReq, .intVector, .intAck, .intReturn,
    .auxPinIn, .auxPinOut, .auxPinOe);
  ext_pin_model i_pins (.auxPinOe, .extLevel, .auxPinIn);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1;
    step(1);
    sfrWr = 0;
  endtask
  task automatic bw(logic [7:0] a, logic v);
    bitAddr = a;
    bitVal = v;
    bitWr = 1;
    step(1);
    bitWr = 0;
  endtask
  task automatic rd(logic [7:0] a, e, string n);
    sfrAddr = a;
    #5 chk(n, e, sfrRdData);
  endtask
  // Waits a bounded time for an offer, then takes it.
  task automatic serve(logic [7:0] e);
    for (int i = 0; i < 20 && intReq !== 1'b1; i++) step(1);
    chk("vector", e, intReq === 1'b1 ? intVector : 8'hFF);
    intAck = 1;
    step(1);
    intAck = 0;
  endtask
  task automatic ret;
    intReturn = 1;
    step(1);
    intReturn = 0;
  endtask
  task automatic t_reset;
    rd(8'hC0, 8'h00, "ctrl");
    sfrRmw = 1;
    rd(8'hD8, 8'h0F, "latch");
    sfrRmw = 0;
    rd(8'h80, 8'h00, "unmapped");
  endtask
  task automatic t_port;
    wr(8'hD8, 8'h0A);
    chk("oe", 8'h05, {4'h0, auxPinOe});
    chk("out", 8'h00, {4'h0, auxPinOut});
    step(3);
    rd(8'hD8, 8'h0A, "pins");
    bw(8'hD8, 1'b1);
    sfrRmw = 1;
    rd(8'hD8, 8'h0B, "rmw");
    sfrRmw = 0;
    wr(8'hD8, 8'h0F);
    step(4);
  endtask
  task automatic t_edge;
    irqEnableReg = 8'h80;
    wr(8'hC0, 8'h01);
    extLevel[2] = 0;
    step(6);
    chk("disabled", 8'h00, {7'h0, intReq});
    rd(8'hC0, 8'h03, "edge flag");
    bw(8'hC2, 1'b1);
    serve(8'h33);
    rd(8'hC0, 8'h05, "flag cleared");
    extLevel[2] = 1;
    ret;
  endtask
  task automatic t_prio;
    wr(8'hC0, 8'hC4);
    extLevel[3:2] = 2'b00;
    serve(8'h3B);
    step(4);
    chk("nesting", 8'h00, {7'h0, intReq});
    rd(8'hC0, 8'hE6, "level flags");
    extLevel[3:2] = 2'b11;
    step(4);
    ret;
    wr(8'hC0, 8'h44);
    extLevel[3:2] = 2'b00;
    serve(8'h33);
    step(2);
    chk("low on low", 8'h00, {7'h0, intReq});
    bw(8'hC7, 1'b1);
    serve(8'h3B);
    extLevel[3:2] = 2'b11;
    step(4);
    ret;
    step(1);
    ret;
  endtask
  task automatic t_std;
    for (int i = 0; i < 6; i++)
    begin
      stdReq = 6'h01 << i;
      irqEnableReg = 8'h80 | (8'h01 << i);
      serve({i[4:0], 3'h3});
      stdReq = 0;
      ret;
    end
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    step(20);
    rstn = 1;
    step(1);
    t_reset;
    t_port;
    t_edge;
    t_prio;
    t_std;
    results;
  end
  initial
  begin
    #100000;
    error_cnt++;
    results;
  end
endmodule
`default_nettype wire
